/* cmps_core.sv */
// current-mode pwm core: oscillator, jitter, soft start, on-latch, blanking
// Function
// - gate ends when amplified sense plus ramp exceeds feedback level
// - cycles at 100 kHz, jittered by 4 kHz over a 4 ms period
// - no jitter during soft start; jitter once normal operation begins
// - on-time never exceeds three quarters of the oscillator period
// - oscillator sets on-latch; feedback, soft start or peak limit clear it
// - gate follows a cleared on-latch at once
// - gate held off about 156 ns after each oscillator trigger
// - ramp held at reset from the duty ceiling to period end, released at cycle start
// - soft start begins when supply rises above turn-on threshold
// - soft start limit rises in 32 steps, one every 300 us
// - soft start ends at 10 ms and its limit is then disabled
// - each auto-restart attempt reruns the full soft start
// - gate low whenever supply is below the off-threshold
// - on-latch cleared in every cycle when peak limit is exceeded and the current slope is not steep
// - comparisons ignored after turn-on: 6 cycles (240 ns) normal, 5 cycles (200 ns) burst
// - burst limit clears the latch only while burst mode is active
// - steeper current slope uses the earlier, lowered limit threshold
// - supply falling below off-threshold clears the soft start counter
`timescale 1ns/10ps

module cmps_core
   import cmps_pkg::*;
#(
   parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,
   parameter int unsigned SS_DUR_CYCLES  = SS_DUR_CYC
)(
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       supply_on,
   input  wire logic       restart_req,
   input  wire logic       burst_mode,
   input  wire logic       duty_compare,
   input  wire logic       peak_limit_compare,
   input  wire logic       peak_limit_early,
   input  wire logic       sense_slope_steep,
   input  wire logic       burst_limit_compare,
   output logic            gate_drive,
   output logic            ramp_reset_switch,
   output logic [4:0]      softstart_level,
   output logic            softstart_active,
   output logic            edge_blanking
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0]          sync_s1_r;
   logic [1:0]          sync_s2_r;
   logic                sup_d_r;
   logic                sup_ok;
   logic                burst_s;
   logic                start_evt;
   logic [8:0]          osc_cnt_r;
   logic [8:0]          osc_cnt_nxt;
   logic [8:0]          period_r;
   logic [8:0]          period_nxt;
   logic [8:0]          on_max_r;
   logic [8:0]          on_max_nxt;
   logic                osc_wrap;

   logic [11:0]         jit_tick_r;
   logic [5:0]          jit_pos_r;
   logic                jit_up_r;
   cmps_ss_e            ss_st_r;
   logic [SS_CNT_W-1:0] ss_step_r;
   logic [SS_CNT_W-1:0] ss_dur_r;
   logic [4:0]          ss_lvl_r;
   logic [13:0]         ss_prod;
   logic [8:0]          ss_lim;

   logic                gate_r;
   logic                gate_nxt;
   logic                ramp_r;
   logic                ss_act_r;
   logic [2:0]          blank_r;
   logic                blank_on_r;
   logic                trip;

   assign gate_drive        = gate_r;
   assign ramp_reset_switch = ramp_r;
   assign softstart_level   = ss_lvl_r;
   assign softstart_active  = ss_act_r;
   assign edge_blanking     = blank_on_r;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   // two-flop sync
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_s1_r <= 2'h0;
         sync_s2_r <= 2'h0;
         sup_d_r   <= 1'b0;
      end else begin
         sync_s1_r <= {burst_mode, supply_on};
         sync_s2_r <= sync_s1_r;
         sup_d_r   <= sync_s2_r[0];
      end
   end

   assign sup_ok  = sync_s2_r[0];
   assign burst_s = sync_s2_r[1];
   assign start_evt = sup_ok & (~sup_d_r | restart_req);

   // ----------------------------------------------------------------
   // oscillator
   // ----------------------------------------------------------------
   // period counted in clock cycles
   always_comb begin
      osc_wrap    = (osc_cnt_r >= period_r - 9'h001) || start_evt;
      osc_cnt_nxt = osc_wrap ? 9'h000 : osc_cnt_r + 9'h001;
      period_nxt  = period_r;
      on_max_nxt  = on_max_r;
      if (osc_wrap) begin
         period_nxt = (ss_st_r == SS_RUN && !start_evt) ?
                      OSC_CYC - 9'(JIT_DEV) + 9'(jit_pos_r) : OSC_CYC;
         on_max_nxt = 9'((10'(period_nxt) * 10'(DUTY_NUM)) / 10'(DUTY_DEN));
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_cnt_r <= OSC_CYC - 9'h001;
         period_r  <= OSC_CYC;
         on_max_r  <= 9'((10'(OSC_CYC) * 10'(DUTY_NUM)) / 10'(DUTY_DEN));
      end else begin
         osc_cnt_r <= osc_cnt_nxt;
         period_r  <= period_nxt;
         on_max_r  <= on_max_nxt;
      end
   end

   // ----------------------------------------------------------------
   // frequency jitter
   // ----------------------------------------------------------------
   // triangle sweep of the period, one cycle per step, centred on nominal
   // jitter only after soft start
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         jit_tick_r <= 12'h000;
         jit_pos_r  <= JIT_DEV;
         jit_up_r   <= 1'b1;
      end else if (ss_st_r != SS_RUN) begin
         jit_tick_r <= 12'h000;
         jit_pos_r  <= JIT_DEV;
         jit_up_r   <= 1'b1;
      end else if (jit_tick_r == JIT_STEP_LAST) begin
         jit_tick_r <= 12'h000;
         if (jit_up_r) begin
            jit_pos_r <= jit_pos_r + 6'h01;
            if (jit_pos_r + 6'h01 == {JIT_DEV[4:0], 1'b0}) begin
               jit_up_r <= 1'b0;
            end
         end else begin
            jit_pos_r <= jit_pos_r - 6'h01;
            if (jit_pos_r == 6'h01) begin
               jit_up_r <= 1'b1;
            end
         end
      end else begin
         jit_tick_r <= jit_tick_r + 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // soft start sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ss_st_r   <= SS_IDLE;
         ss_step_r <= '0;
         ss_dur_r  <= '0;
         ss_lvl_r  <= 5'h00;
      end else if (!sup_ok) begin
         ss_st_r   <= SS_IDLE;
         ss_step_r <= '0;
         ss_dur_r  <= '0;
         ss_lvl_r  <= 5'h00;
      end else if (start_evt) begin
         ss_st_r   <= SS_RAMP;
         ss_step_r <= '0;
         ss_dur_r  <= '0;
         ss_lvl_r  <= 5'h00;
      end else begin
         unique case (ss_st_r)
            SS_IDLE, SS_RUN: begin
               ss_st_r <= ss_st_r;
            end
            SS_RAMP: begin
               if (ss_step_r == SS_CNT_W'(SS_STEP_CYCLES - 1)) begin
                  ss_step_r <= '0;
                  if (ss_lvl_r != SS_LVL_MAX) begin
                     ss_lvl_r <= ss_lvl_r + 5'h01;
                  end
               end else begin
                  ss_step_r <= ss_step_r + SS_CNT_W'(1);
               end
               if (ss_dur_r == SS_CNT_W'(SS_DUR_CYCLES - 1)) begin
                  ss_st_r <= SS_RUN;
               end else begin
                  ss_dur_r <= ss_dur_r + SS_CNT_W'(1);
               end
            end
            default: begin
               ss_st_r <= SS_IDLE;
            end
         endcase
      end
   end

   // limit is level/32 of the ceiling
   assign ss_prod = 14'(on_max_nxt) * 14'(ss_lvl_r);
   assign ss_lim  = ss_prod[13:SS_LVL_W];

   // ----------------------------------------------------------------
   // on-latch and gate
   // ----------------------------------------------------------------
   // raw comparators reach the latch directly: no sync delay on turn-off
   always_comb begin
      // steep slope selects the lowered threshold
      trip = sense_slope_steep ? peak_limit_early : peak_limit_compare;
      trip = trip | duty_compare;
      // burst limit only in burst mode
      trip = trip | (burst_s & burst_limit_compare);
      trip = trip & (blank_r == 3'h0);
   end

   always_comb begin
      gate_nxt = gate_r;
      // set after the hold-off from the oscillator pulse
      if (osc_cnt_nxt == MIN_DLY_CYC) begin
         gate_nxt = 1'b1;
      end
      if (osc_cnt_nxt >= on_max_nxt) begin
         gate_nxt = 1'b0;
      end
      if (ss_st_r == SS_RAMP && osc_cnt_nxt >= ss_lim) begin
         gate_nxt = 1'b0;
      end
      // any trip ends the on-time at once
      if (gate_r && trip) begin
         gate_nxt = 1'b0;
      end
      // off below threshold and before a start
      if (!sup_ok || ss_st_r == SS_IDLE || start_evt) begin
         gate_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_r   <= 1'b0;
         ramp_r   <= 1'b1;
         ss_act_r <= 1'b0;
      end else begin
         gate_r   <= gate_nxt;
         ramp_r   <= osc_cnt_nxt >= on_max_nxt;
         ss_act_r <= ss_st_r == SS_RAMP;
      end
   end

   // ----------------------------------------------------------------
   // leading edge blanking
   // ----------------------------------------------------------------
   // window length chosen by mode
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         blank_r    <= 3'h0;
         blank_on_r <= 1'b0;
      end else if (gate_nxt && !gate_r) begin
         blank_r    <= burst_s ? LEB_BURST_CYC : LEB_NORM_CYC;
         blank_on_r <= 1'b1;
      end else if (!gate_nxt) begin
         blank_r    <= 3'h0;
         blank_on_r <= 1'b0;
      end else if (blank_r != 3'h0) begin
         blank_r    <= blank_r - 3'h1;
         blank_on_r <= blank_r != 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_gate_rise;
      !gate_r ##1 gate_r;
   endsequence

   sequence s_blank_hold;
      (edge_blanking || !gate_r) [*5];
   endsequence

   property p_fb_off;
      @(posedge sys_clk) disable iff (!arst_n)
      gate_r && !edge_blanking && duty_compare |=> !gate_r;
   endproperty
   a_fb_off: assert property (p_fb_off) else $error("gate kept on past feedback");

   property p_nominal_period;
      @(posedge sys_clk) disable iff (!arst_n)
      ss_st_r == SS_RAMP |-> period_r == OSC_CYC;
   endproperty
   a_nominal_period: assert property (p_nominal_period) else $error("jitter in soft start");

   property p_ceiling;
      @(posedge sys_clk) disable iff (!arst_n)
      gate_r |-> 10'(osc_cnt_r) * 10'h004 < 10'(period_r) * 10'h003;
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("on-time over ceiling");

   property p_hold_off;
      @(posedge sys_clk) disable iff (!arst_n)
      s_gate_rise |-> osc_cnt_r == MIN_DLY_CYC;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("gate on without hold-off");

   property p_ramp;
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(ramp_r) |-> osc_cnt_r == 9'h000 ##1 !ramp_r;
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp released off cycle start");

   property p_ss_start;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(sup_ok) |=> ss_st_r == SS_RAMP && ss_lvl_r == 5'h00;
   endproperty
   a_ss_start: assert property (p_ss_start) else $error("soft start not begun");

   property p_uvlo;
      @(posedge sys_clk) disable iff (!arst_n)
      !sup_ok |=> !gate_r && ss_lvl_r == 5'h00;
   endproperty
   a_uvlo: assert property (p_uvlo) else $error("gate or level kept under lockout");

   property p_peak;
      @(posedge sys_clk) disable iff (!arst_n)
      gate_r && !edge_blanking && !sense_slope_steep && peak_limit_compare |=> !gate_r;
   endproperty
   a_peak: assert property (p_peak) else $error("peak limit ignored");

   property p_blank;
      @(posedge sys_clk) disable iff (!arst_n)
      s_gate_rise |-> s_blank_hold;
   endproperty
   a_blank: assert property (p_blank) else $error("blanking too short");

   property p_burst;
      @(posedge sys_clk) disable iff (!arst_n)
      gate_r && !edge_blanking && burst_s && burst_limit_compare |=> !gate_r;
   endproperty
   a_burst: assert property (p_burst) else $error("burst limit ignored");

endmodule

/* cmps_pkg.sv */
// timing constants and types for the current-mode pwm core
package cmps_pkg;

   // ----------------------------------------------------------------
   // printed figures, in their own units
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned OSC_FREQ_KHZ  = 100;
   localparam int unsigned JIT_DEV_KHZ   = 4;
   localparam int unsigned JIT_PERIOD_US = 4000;
   localparam int unsigned DUTY_NUM      = 3;
   localparam int unsigned DUTY_DEN      = 4;
   localparam int unsigned MIN_DLY_NS    = 156;
   localparam int unsigned LEB_NORM_NS   = 220;
   localparam int unsigned LEB_BURST_NS  = 180;
   localparam int unsigned SS_STEPS      = 32;
   localparam int unsigned SS_STEP_US    = 300;
   localparam int unsigned SS_DUR_MS     = 10;

   // ----------------------------------------------------------------
   // derived cycle counts
   // ----------------------------------------------------------------
   localparam int unsigned OSC_CYC_I  = 1000000 / (OSC_FREQ_KHZ * CLK_PERIOD_NS);
   localparam int unsigned JIT_DEV_I  =
      1000000 / ((OSC_FREQ_KHZ - JIT_DEV_KHZ) * CLK_PERIOD_NS) - OSC_CYC_I;
   localparam int unsigned JIT_STEP_I =
      (JIT_PERIOD_US * 1000 / CLK_PERIOD_NS) / (4 * JIT_DEV_I);
   localparam int unsigned SS_STEP_CYC = SS_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned SS_DUR_CYC  = SS_DUR_MS * 1000000 / CLK_PERIOD_NS;

   localparam logic [8:0]  OSC_CYC       = 9'(OSC_CYC_I);
   localparam logic [5:0]  JIT_DEV       = 6'(JIT_DEV_I);
   localparam logic [11:0] JIT_STEP_LAST = 12'(JIT_STEP_I - 1);
   localparam logic [8:0]  MIN_DLY_CYC   =
      9'((MIN_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0]  LEB_NORM_CYC  =
      3'((LEB_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0]  LEB_BURST_CYC =
      3'((LEB_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int unsigned SS_LVL_W      = 5;
   localparam logic [4:0]  SS_LVL_MAX    = 5'(SS_STEPS - 1);
   localparam int unsigned SS_CNT_W      = 18;

   typedef enum logic [2:0] {
      SS_IDLE = 3'h1,
      SS_RAMP = 3'h2,
      SS_RUN  = 3'h4
   } cmps_ss_e;

endpackage

/* cmps_sense_model.sv */
// behavioural feedback and current-sense comparators facing the pwm core
`timescale 1ns/10ps

module cmps_sense_model (
   input  wire logic        sys_clk,
   input  wire logic        gate_drive,
   input  wire logic [1:0]  trip_sel,
   input  wire logic [15:0] trip_at,
   input  wire logic [15:0] trip_len,
   output logic             duty_compare,
   output logic             peak_limit_compare,
   output logic             peak_limit_early,
   output logic             burst_limit_compare
);
   int   on_cnt;
   logic trip;

   initial begin
      on_cnt = 0;
      duty_compare = 1'b0;
      peak_limit_compare = 1'b0;
      peak_limit_early = 1'b0;
      burst_limit_compare = 1'b0;
   end

   // ----------------------------------------------------------------
   // sense ramp
   // ----------------------------------------------------------------
   // current only rises while the switch conducts, so a trip drops with the gate
   always @(negedge sys_clk) begin
      on_cnt = (gate_drive === 1'b1) ? on_cnt + 1 : 0;
      trip = (trip_at != 16'h0000) && (on_cnt >= int'(trip_at))
             && ((trip_len == 16'h0000) || (on_cnt < int'(trip_at) + int'(trip_len)));
      duty_compare <= trip && (trip_sel == 2'h0);
      peak_limit_compare <= trip && (trip_sel == 2'h1);
      peak_limit_early <= trip && (trip_sel == 2'h2);
      burst_limit_compare <= trip && (trip_sel == 2'h3);
   end
endmodule

/* current_mode_pwm_softstart_bench.sv */
// self-checking bench for the current-mode pwm core
`timescale 1ns/10ps

module current_mode_pwm_softstart_bench;
   localparam int STEP = 20;
   localparam int DUR  = 700;

   logic        sys_clk, arst_n, supply_on, restart_req, burst_mode, sense_slope_steep;
   logic        duty_compare, peak_limit_compare, peak_limit_early, burst_limit_compare;
   logic        gate_drive, ramp_reset_switch, softstart_active, edge_blanking;
   logic [4:0]  softstart_level;
   logic [1:0]  trip_sel;
   logic [15:0] trip_at, trip_len;
   int          num_errors, check_count;
   // columns: selector, steep, burst, trip cycle, pulse length, on-time (0 = ceiling)
   int          rows[12][6] = '{
      '{0, 0, 0, 40, 0, 40}, '{1, 0, 0, 60, 0, 60}, '{2, 1, 0, 30, 0, 30},
      '{2, 0, 0, 30, 0, 0},  '{1, 1, 0, 30, 0, 0},  '{3, 0, 0, 30, 0, 0},
      '{3, 0, 1, 30, 0, 30}, '{0, 0, 1, 2, 0, 6},   '{0, 0, 0, 2, 0, 7},
      '{0, 0, 0, 2, 3, 0},   '{0, 0, 0, 6, 1, 0},   '{0, 0, 0, 7, 1, 7}};

   cmps_core #(.SS_STEP_CYCLES(STEP), .SS_DUR_CYCLES(DUR)) u_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .supply_on(supply_on),
      .restart_req(restart_req), .burst_mode(burst_mode), .duty_compare(duty_compare),
      .peak_limit_compare(peak_limit_compare), .peak_limit_early(peak_limit_early),
      .sense_slope_steep(sense_slope_steep), .burst_limit_compare(burst_limit_compare),
      .gate_drive(gate_drive), .ramp_reset_switch(ramp_reset_switch),
      .softstart_level(softstart_level), .softstart_active(softstart_active),
      .edge_blanking(edge_blanking));

   cmps_sense_model u_sense (
      .sys_clk(sys_clk), .gate_drive(gate_drive), .trip_sel(trip_sel),
      .trip_at(trip_at), .trip_len(trip_len), .duty_compare(duty_compare),
      .peak_limit_compare(peak_limit_compare), .peak_limit_early(peak_limit_early),
      .burst_limit_compare(burst_limit_compare));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // compare and closing tasks
   // ----------------------------------------------------------------
   task automatic chk_bit(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one oscillator period from ramp release: period, ramp-low span, on-time, hold-off
   task automatic meas(output int p, output int l, output int h, output int d);
      int n;
      n = 0;
      while (ramp_reset_switch !== 1'b1 && n < 600) begin
         @(negedge sys_clk);
         n++;
      end
      while (ramp_reset_switch !== 1'b0 && n < 1200) begin
         @(negedge sys_clk);
         n++;
      end
      p = 0;
      l = -1;
      h = 0;
      d = -1;
      do begin
         if (gate_drive === 1'b1) begin
            h++;
            if (d < 0) d = p;
         end
         if (ramp_reset_switch === 1'b1 && l < 0) l = p;
         @(negedge sys_clk);
         p++;
      end while (!(ramp_reset_switch === 1'b0 && l >= 0) && p < 600);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // gate held low
   task automatic t_reset_idle(input bit after_rst);
      int hi;
      hi = 0;
      chk_bit(8'(gate_drive), 8'h00);
      if (after_rst) begin
         chk_bit(8'(ramp_reset_switch), 8'h01);
      end
      chk_bit(8'(softstart_level), 8'h00);
      chk_bit(8'({softstart_active, edge_blanking}), 8'h00);
      repeat (600) begin
         @(negedge sys_clk);
         hi += int'(gate_drive !== 1'b0);
      end
      chk_cnt(hi, 0);
   endtask

   task automatic t_softstart();
      int n;
      n = 0;
      while (softstart_active !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      chk_bit(8'(softstart_active), 8'h01);
      repeat (STEP / 2) @(negedge sys_clk);
      for (int k = 0; k < DUR / STEP; k++) begin
         chk_bit(8'(softstart_level), 8'((k < 31) ? k : 31));
         chk_bit(8'(softstart_active), 8'h01);
         repeat (STEP) @(negedge sys_clk);
      end
      chk_bit(8'(softstart_active), 8'h00);
   endtask

   task automatic t_trips();
      int p, l, h, d, e;
      for (int r = 0; r < 12; r++) begin
         trip_sel = 2'(rows[r][0]);
         sense_slope_steep = rows[r][1][0];
         burst_mode = rows[r][2][0];
         trip_at = 16'(rows[r][3]);
         trip_len = 16'(rows[r][4]);
         meas(p, l, h, d);
         meas(p, l, h, d);
         e = (rows[r][5] == 0) ? l - 4 : rows[r][5];
         chk_cnt(h, e);
      end
      trip_at = 16'h0000;
      burst_mode = 1'b0;
   endtask

   task automatic t_jitter();
      int p, l, h, d, prev, moved;
      meas(p, l, h, d);
      prev = p;
      moved = 0;
      for (int i = 0; i < 25; i++) begin
         meas(p, l, h, d);
         chk_cnt(int'(p >= 240 && p <= 260 && p - prev <= 1 && prev - p <= 1), 1);
         chk_cnt(l, p * 3 / 4);
         chk_cnt(d, 4);
         chk_cnt(h, l - 4);
         moved += int'(p != 250);
         prev = p;
      end
      chk_cnt(int'(moved > 0), 1);
   endtask

   task automatic t_restart();
      int p, l, h, d, n;
      restart_req = 1'b1;
      @(negedge sys_clk);
      restart_req = 1'b0;
      n = 0;
      while (softstart_active !== 1'b1 && n < 10) begin
         @(negedge sys_clk);
         n++;
      end
      chk_bit(8'({softstart_active, softstart_level}), 8'h20);
      meas(p, l, h, d);
      chk_cnt(p, 250);
      while (softstart_active !== 1'b0 && n < 900) begin
         @(negedge sys_clk);
         n++;
      end
      chk_bit(8'(softstart_active), 8'h00);
   endtask

   task automatic t_supply_drop();
      supply_on = 1'b0;
      repeat (5) @(negedge sys_clk);
      chk_bit(8'({gate_drive, softstart_active, softstart_level}), 8'h00);
      t_reset_idle(1'b0);
      supply_on = 1'b1;
      t_softstart();
   endtask

   initial begin
      num_errors = 0;
      check_count = 0;
      arst_n = 1'b0;
      supply_on = 1'b0;
      restart_req = 1'b0;
      burst_mode = 1'b0;
      sense_slope_steep = 1'b0;
      trip_sel = 2'h0;
      trip_at = 16'h0000;
      trip_len = 16'h0000;
      repeat (5) @(negedge sys_clk);
      arst_n = 1'b1;
      t_reset_idle(1'b1);
      supply_on = 1'b1;
      t_softstart();
      t_trips();
      t_jitter();
      t_restart();
      t_supply_drop();
      results();
   end

   // hang guard, well beyond the roughly 28000 cycles of the sequence
   initial begin
      repeat (80000) @(posedge sys_clk);
      num_errors++;
      results();
   end
endmodule
